// File: hw/nfh_pkg.sv
// Purpose: Constants for the NAND flash host sequencer
// Assumes: 125 MHz clock, 8 ns period
// Notes:   Times kept in ns/us, cycle counts derived here
package nfh_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  // Strobe timing, minimum times rounded up to whole cycles
  localparam int unsigned T_SETUP_NS     = 20;
  localparam int unsigned T_PULSE_NS     = 12;
  localparam int unsigned T_HIGH_NS      = 10;
  localparam int unsigned T_REA_NS       = 20;
  localparam int unsigned T_WHR_NS       = 60;
  localparam int unsigned T_RHW_NS       = 30;
  localparam int unsigned T_WB_NS        = 100;
  localparam int unsigned T_RR_NS        = 20;
  localparam int unsigned CYC_SETUP      = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_PULSE      = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_HIGH       = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_REA        = (T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_WHR        = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RHW        = (T_RHW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_WB         = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RR         = (T_RR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Busy watchdog: longest documented busy is erase reset, 500 us
  localparam int unsigned T_BUSY_MAX_US  = 500;
  localparam int unsigned CYC_BUSY_MAX   = T_BUSY_MAX_US * 1000 / CLK_PERIOD_NS;
  // Command bytes
  localparam logic [7:0] CMD_READ_1      = 8'h00;
  localparam logic [7:0] CMD_READ_2      = 8'h30;
  localparam logic [7:0] CMD_PROG_1      = 8'h80;
  localparam logic [7:0] CMD_PROG_2      = 8'h10;
  localparam logic [7:0] CMD_ECC_STATUS  = 8'h7A;
  localparam logic [7:0] CMD_RESET       = 8'hFF;
  localparam int unsigned ADDR_CYCLES    = 4;
  localparam int unsigned ECC_SECTORS    = 4;
  localparam int unsigned MAX_PARTIAL    = 4;
  localparam int unsigned PAGE_BYTES     = 2112;
  // Host operations
  localparam logic [2:0] OP_READ         = 3'h0;
  localparam logic [2:0] OP_PROG         = 3'h1;
  localparam logic [2:0] OP_ECC          = 3'h2;
  localparam logic [2:0] OP_RESET        = 3'h3;
  localparam logic [2:0] OP_ERASED       = 3'h4;
  // Strobe cycle kinds for the timing engine
  typedef enum logic [1:0] {
    NFH_CYC_CMD  = 2'h0,
    NFH_CYC_ADDR = 2'h1,
    NFH_CYC_DIN  = 2'h2,
    NFH_CYC_DOUT = 2'h3
  } nfh_cyc_e;
endpackage

// File: hw/nfh_cyc_if.sv
// Purpose: Carrier between sequencer and strobe engine
// Assumes: Single clock
// Notes:   One request at a time, done is a one-cycle pulse
`timescale 1ns/10ps
interface nfh_cyc_if;
  logic              req;
  nfh_pkg::nfh_cyc_e kind;
  logic [7:0]        wdata;
  logic              done;
  logic [7:0]        rdata;
  modport seq (output req, output kind, output wdata, input done, input rdata);
  modport eng (input req, input kind, input wdata, output done, output rdata);
endinterface

// File: hw/nfh_strobe.sv
// Purpose: Generates one command, address, data-in or data-out bus cycle
// Assumes: Device pins are synchronous to clk
// Notes:   All pin outputs registered
`timescale 1ns/10ps
module nfh_strobe (
  input  wire logic clk,
  input  wire logic rst_n,
  nfh_cyc_if.eng    cyc,
  output logic      cmd_latch_r,
  output logic      addr_latch_r,
  output logic      write_strobe_n_r,
  output logic      read_strobe_n_r,
  output logic [7:0] io_out_r,
  output logic      io_oe_r,
  input  wire logic [7:0] io_in
);
  typedef enum logic [3:0] {
    NFH_S_IDLE  = 4'b0001,
    NFH_S_SETUP = 4'b0010,
    NFH_S_LOW   = 4'b0100,
    NFH_S_HIGH  = 4'b1000
  } nfh_st_e;

  nfh_st_e     st_r, st_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic        cl_nxt, al_nxt, we_nxt, re_nxt, oe_nxt, done_nxt, done_r;
  logic [7:0]  io_nxt, rd_r, rd_nxt;
  logic        is_rd;

  assign is_rd     = (cyc.kind == nfh_pkg::NFH_CYC_DOUT);
  assign cyc.done  = done_r;
  assign cyc.rdata = rd_r;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    cl_nxt   = cmd_latch_r;
    al_nxt   = addr_latch_r;
    we_nxt   = write_strobe_n_r;
    re_nxt   = read_strobe_n_r;
    oe_nxt   = io_oe_r;
    io_nxt   = io_out_r;
    rd_nxt   = rd_r;
    done_nxt = 1'b0;
    case (st_r)
      NFH_S_IDLE: begin
        // Request still shows the finished cycle while done stands
        if (cyc.req && !done_r) begin
          cl_nxt  = (cyc.kind == nfh_pkg::NFH_CYC_CMD);
          al_nxt  = (cyc.kind == nfh_pkg::NFH_CYC_ADDR);
          // Drive bus only on writes, never while device outputs
          oe_nxt  = !is_rd;
          io_nxt  = cyc.wdata;
          cnt_nxt = 4'(nfh_pkg::CYC_SETUP);
          st_nxt  = NFH_S_SETUP;
        end
      end
      NFH_S_SETUP: begin
        if (cnt_r > 4'h1) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          if (is_rd) begin
            re_nxt  = 1'b0;
            cnt_nxt = 4'(nfh_pkg::CYC_REA);
          end else begin
            we_nxt  = 1'b0;
            cnt_nxt = 4'(nfh_pkg::CYC_PULSE);
          end
          st_nxt = NFH_S_LOW;
        end
      end
      NFH_S_LOW: begin
        if (cnt_r > 4'h1) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          // Sample before the rising edge, data valid after access delay
          if (is_rd) begin
            rd_nxt = io_in;
          end
          // Rising write edge latches command, address or data
          we_nxt  = 1'b1;
          re_nxt  = 1'b1;
          cnt_nxt = 4'(nfh_pkg::CYC_HIGH);
          st_nxt  = NFH_S_HIGH;
        end
      end
      default: begin
        if (cnt_r > 4'h1) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          cl_nxt   = 1'b0;
          al_nxt   = 1'b0;
          oe_nxt   = 1'b0;
          done_nxt = 1'b1;
          st_nxt   = NFH_S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r             <= NFH_S_IDLE;
      cnt_r            <= 4'h0;
      cmd_latch_r      <= 1'b0;
      addr_latch_r     <= 1'b0;
      write_strobe_n_r <= 1'b1;
      read_strobe_n_r  <= 1'b1;
      io_oe_r          <= 1'b0;
      io_out_r         <= 8'h00;
      rd_r             <= 8'h00;
      done_r           <= 1'b0;
    end else begin
      st_r             <= st_nxt;
      cnt_r            <= cnt_nxt;
      cmd_latch_r      <= cl_nxt;
      addr_latch_r     <= al_nxt;
      write_strobe_n_r <= we_nxt;
      read_strobe_n_r  <= re_nxt;
      io_oe_r          <= oe_nxt;
      io_out_r         <= io_nxt;
      rd_r             <= rd_nxt;
      done_r           <= done_nxt;
    end
  end

  a_strobe_never_both : assert property (@(posedge clk) disable iff (!rst_n)
    !(!write_strobe_n_r && !read_strobe_n_r)) else $error("write and read strobes low together");
  a_no_drive_on_read : assert property (@(posedge clk) disable iff (!rst_n)
    !read_strobe_n_r |-> !io_oe_r) else $error("host drives bus while reading");
  a_latch_held_write : assert property (@(posedge clk) disable iff (!rst_n)
    $rose(write_strobe_n_r) |-> (cmd_latch_r == $past(cmd_latch_r))) else $error("latch moved at write edge");
endmodule

// File: hw/nfh_host.sv
// Purpose: Host-side NAND flash sequencer for read, program, ECC status and reset
// Assumes: Device pins synchronous to clk; open-drain ready/busy pulled up externally
// Notes:   One operation at a time; start accepted only when busy_r is low
// Behaviour
// - Host issues at most four successive partial programs per page before erase; programming another page restarts the count
// - ECC status read fetches all four sector bytes
// - ECC status command only after ready, before data or commands; host issues it on any OP_ECC start from idle, unchecked
// - Host never drives I/O while device outputs data
// - Read: first command, address, confirm command
// - Address is four cycles: two column, two row bytes
`timescale 1ns/10ps
module nfh_host #(
  parameter int unsigned BUSY_MAX_CYC = nfh_pkg::CYC_BUSY_MAX
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [2:0]  op,
  input  wire logic [15:0] column,
  input  wire logic [15:0] row,
  input  wire logic [11:0] length,
  input  wire logic [7:0]  wr_byte,
  output logic             wr_take_r,
  output logic [7:0]       rd_byte_r,
  output logic             rd_valid_r,
  output logic             busy_r,
  output logic             done_r,
  output logic             error_r,
  output logic             chip_sel_n_r,
  output logic             cmd_latch,
  output logic             addr_latch,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic [7:0]       io_out,
  output logic             io_oe,
  input  wire logic [7:0]  io_in,
  input  wire logic        ready_busy_n
);
  typedef enum logic [7:0] {
    NFH_IDLE  = 8'b00000001,
    NFH_CMD1  = 8'b00000010,
    NFH_ADDR  = 8'b00000100,
    NFH_DATA  = 8'b00001000,
    NFH_CMD2  = 8'b00010000,
    NFH_WAIT  = 8'b00100000,
    NFH_ECC   = 8'b01000000,
    NFH_XFER  = 8'b10000000
  } nfh_host_e;

  nfh_cyc_if cyc ();

  nfh_host_e   st_r, st_nxt;
  logic [2:0]  op_r, op_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [11:0] left_r, left_nxt;
  logic [1:0]  idx_r, idx_nxt;
  logic [2:0]  part_r, part_nxt;
  logic [15:0] prow_r, prow_nxt;
  logic [19:0] tmo_r, tmo_nxt;
  logic        pend_r, pend_nxt;
  logic        wt_nxt, rv_nxt, by_nxt, dn_nxt, er_nxt, cs_nxt;
  logic [7:0]  rb_nxt;
  nfh_pkg::nfh_cyc_e kind_r, kind_nxt;
  logic [7:0]  wd_r, wd_nxt;

  assign cyc.req   = pend_r;
  assign cyc.kind  = kind_r;
  assign cyc.wdata = wd_r;

  nfh_strobe u_strobe (
    .clk              (clk),
    .rst_n            (rst_n),
    .cyc              (cyc.eng),
    .cmd_latch_r      (cmd_latch),
    .addr_latch_r     (addr_latch),
    .write_strobe_n_r (write_strobe_n),
    .read_strobe_n_r  (read_strobe_n),
    .io_out_r         (io_out),
    .io_oe_r          (io_oe),
    .io_in            (io_in)
  );

  always_comb begin
    st_nxt   = st_r;
    op_nxt   = op_r;
    addr_nxt = addr_r;
    left_nxt = left_r;
    idx_nxt  = idx_r;
    part_nxt = part_r;
    prow_nxt = prow_r;
    tmo_nxt  = tmo_r;
    pend_nxt = pend_r;
    kind_nxt = kind_r;
    wd_nxt   = wd_r;
    wt_nxt   = 1'b0;
    rv_nxt   = 1'b0;
    rb_nxt   = rd_byte_r;
    dn_nxt   = 1'b0;
    er_nxt   = error_r;
    by_nxt   = busy_r;
    cs_nxt   = chip_sel_n_r;
    if (cyc.done) begin
      pend_nxt = 1'b0;
    end
    case (st_r)
      NFH_IDLE: begin
        // Chip select released whenever idle, ready or not, lets device sleep
        cs_nxt = 1'b1;
        if (start) begin
          op_nxt   = op;
          addr_nxt = {row, 4'h0, column[11:0]};
          left_nxt = length;
          idx_nxt  = 2'h0;
          by_nxt   = 1'b1;
          er_nxt   = 1'b0;
          cs_nxt   = 1'b0;
          if (op == nfh_pkg::OP_ERASED) begin
            part_nxt = 3'h0;
            by_nxt   = 1'b0;
            dn_nxt   = 1'b1;
          end else if (op == nfh_pkg::OP_PROG && row == prow_r && part_r >= 3'(nfh_pkg::MAX_PARTIAL)) begin
            er_nxt = 1'b1;
            by_nxt = 1'b0;
            dn_nxt = 1'b1;
          end else begin
            st_nxt   = NFH_CMD1;
            pend_nxt = 1'b1;
            kind_nxt = nfh_pkg::NFH_CYC_CMD;
            case (op)
              nfh_pkg::OP_PROG:  wd_nxt = nfh_pkg::CMD_PROG_1;
              nfh_pkg::OP_ECC:   wd_nxt = nfh_pkg::CMD_ECC_STATUS;
              nfh_pkg::OP_RESET: wd_nxt = nfh_pkg::CMD_RESET;
              default:           wd_nxt = nfh_pkg::CMD_READ_1;
            endcase
          end
        end
      end
      NFH_CMD1: begin
        if (cyc.done) begin
          if (op_r == nfh_pkg::OP_RESET) begin
            tmo_nxt = 20'(BUSY_MAX_CYC);
            st_nxt  = NFH_WAIT;
          end else if (op_r == nfh_pkg::OP_ECC) begin
            st_nxt   = NFH_ECC;
            pend_nxt = 1'b1;
            kind_nxt = nfh_pkg::NFH_CYC_DOUT;
          end else begin
            st_nxt   = NFH_ADDR;
            pend_nxt = 1'b1;
            kind_nxt = nfh_pkg::NFH_CYC_ADDR;
            wd_nxt   = addr_r[7:0];
          end
        end
      end
      NFH_ADDR: begin
        if (cyc.done) begin
          // Column low, column high, row low, row high
          addr_nxt = {8'h00, addr_r[31:8]};
          idx_nxt  = idx_r + 2'h1;
          pend_nxt = 1'b1;
          if (idx_r == 2'(nfh_pkg::ADDR_CYCLES - 1)) begin
            if (op_r == nfh_pkg::OP_PROG && left_r != 12'h000) begin
              st_nxt   = NFH_DATA;
              kind_nxt = nfh_pkg::NFH_CYC_DIN;
              wd_nxt   = wr_byte;
              wt_nxt   = 1'b1;
            end else begin
              st_nxt   = NFH_CMD2;
              kind_nxt = nfh_pkg::NFH_CYC_CMD;
              wd_nxt   = (op_r == nfh_pkg::OP_PROG) ? nfh_pkg::CMD_PROG_2 : nfh_pkg::CMD_READ_2;
            end
          end else begin
            wd_nxt = addr_nxt[7:0];
          end
        end
      end
      NFH_DATA: begin
        if (cyc.done) begin
          left_nxt = left_r - 12'h001;
          pend_nxt = 1'b1;
          if (left_r == 12'h001) begin
            st_nxt   = NFH_CMD2;
            kind_nxt = nfh_pkg::NFH_CYC_CMD;
            wd_nxt   = nfh_pkg::CMD_PROG_2;
          end else begin
            wd_nxt = wr_byte;
            wt_nxt = 1'b1;
          end
        end
      end
      NFH_CMD2: begin
        if (cyc.done) begin
          if (op_r == nfh_pkg::OP_PROG) begin
            part_nxt = (row == prow_r) ? part_r + 3'h1 : 3'h1;
            prow_nxt = row;
          end
          tmo_nxt = 20'(BUSY_MAX_CYC);
          st_nxt  = NFH_WAIT;
        end
      end
      NFH_WAIT: begin
        // Chip select held low, device ignores it during busy anyway
        tmo_nxt = tmo_r - 20'h00001;
        if (tmo_r < 20'(BUSY_MAX_CYC - nfh_pkg::CYC_WB - nfh_pkg::CYC_RR) && ready_busy_n) begin
          if (op_r == nfh_pkg::OP_READ && left_r != 12'h000) begin
            st_nxt   = NFH_XFER;
            pend_nxt = 1'b1;
            kind_nxt = nfh_pkg::NFH_CYC_DOUT;
          end else begin
            st_nxt = NFH_IDLE;
            by_nxt = 1'b0;
            dn_nxt = 1'b1;
          end
        end else if (tmo_r == 20'h00000) begin
          er_nxt = 1'b1;
          by_nxt = 1'b0;
          dn_nxt = 1'b1;
          st_nxt = NFH_IDLE;
        end
      end
      NFH_ECC: begin
        if (cyc.done) begin
          rv_nxt  = 1'b1;
          rb_nxt  = cyc.rdata;
          idx_nxt = idx_r + 2'h1;
          if (idx_r == 2'(nfh_pkg::ECC_SECTORS - 1)) begin
            st_nxt = NFH_IDLE;
            by_nxt = 1'b0;
            dn_nxt = 1'b1;
          end else begin
            pend_nxt = 1'b1;
          end
        end
      end
      default: begin
        if (cyc.done) begin
          rv_nxt   = 1'b1;
          rb_nxt   = cyc.rdata;
          left_nxt = left_r - 12'h001;
          if (left_r == 12'h001) begin
            st_nxt = NFH_IDLE;
            by_nxt = 1'b0;
            dn_nxt = 1'b1;
          end else begin
            pend_nxt = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r         <= NFH_IDLE;
      op_r         <= 3'h0;
      addr_r       <= 32'h0000_0000;
      left_r       <= 12'h000;
      idx_r        <= 2'h0;
      part_r       <= 3'h0;
      prow_r       <= 16'hFFFF;
      tmo_r        <= 20'h00000;
      pend_r       <= 1'b0;
      kind_r       <= nfh_pkg::NFH_CYC_CMD;
      wd_r         <= 8'h00;
      wr_take_r    <= 1'b0;
      rd_valid_r   <= 1'b0;
      rd_byte_r    <= 8'h00;
      done_r       <= 1'b0;
      error_r      <= 1'b0;
      busy_r       <= 1'b0;
      chip_sel_n_r <= 1'b1;
    end else begin
      st_r         <= st_nxt;
      op_r         <= op_nxt;
      addr_r       <= addr_nxt;
      left_r       <= left_nxt;
      idx_r        <= idx_nxt;
      part_r       <= part_nxt;
      prow_r       <= prow_nxt;
      tmo_r        <= tmo_nxt;
      pend_r       <= pend_nxt;
      kind_r       <= kind_nxt;
      wd_r         <= wd_nxt;
      wr_take_r    <= wt_nxt;
      rd_valid_r   <= rv_nxt;
      rd_byte_r    <= rb_nxt;
      done_r       <= dn_nxt;
      error_r      <= er_nxt;
      busy_r       <= by_nxt;
      chip_sel_n_r <= cs_nxt;
    end
  end

  a_partial_limit : assert property (@(posedge clk) disable iff (!rst_n)
    part_r <= 3'(nfh_pkg::MAX_PARTIAL)) else $error("partial program count exceeded");
  a_ecc_four_bytes : assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == NFH_ECC && st_nxt == NFH_IDLE) |-> idx_r == 2'h3) else $error("ECC status read short");
  a_wait_ready_only : assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == NFH_WAIT && st_nxt != NFH_WAIT && !error_r && er_nxt == 1'b0) |-> ready_busy_n)
    else $error("left busy wait while busy");
  a_addr_four_cycles : assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == NFH_CMD1 && st_nxt == NFH_ADDR) |-> ##[1:200] (st_r == NFH_ADDR && idx_r == 2'h3))
    else $error("address phase not four cycles");
  a_cs_low_busy : assert property (@(posedge clk) disable iff (!rst_n)
    (st_r != NFH_IDLE) |-> !chip_sel_n_r) else $error("chip select high during operation");
  c_read_done : cover property (@(posedge clk) disable iff (!rst_n) st_r == NFH_XFER && done_r == 1'b0 ##1 done_r);
  c_prog_wait : cover property (@(posedge clk) disable iff (!rst_n) st_r == NFH_DATA ##[1:300] st_r == NFH_WAIT);
  c_ecc_read : cover property (@(posedge clk) disable iff (!rst_n) st_r == NFH_ECC ##[1:300] st_r == NFH_IDLE);
endmodule

// File: verification/nfh_flash_model.sv
// Purpose: Behavioural flash device facing the host sequencer
// Assumes: Pins sampled on clk; data lines float to inverse of last byte
// Notes:   Logs latched command/address bytes for the bench
`timescale 1ns/10ps
module nfh_flash_model #(
  parameter int BUSY_CYC = 40
) (
  input  wire logic       clk,
  input  wire logic       chip_sel_n,
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [7:0] io_out,
  input  wire logic       io_oe,
  input  wire logic       stuck,
  output logic [7:0]      io_in,
  output logic            ready_busy_n
);
  logic [7:0]  mem [0:4095];
  logic [8:0]  log_q [$];
  logic [7:0]  cmd_r     = 8'h00;
  logic [7:0]  last_r    = 8'h00;
  logic [11:0] col_r     = 12'h000;
  logic [1:0]  acnt_r    = 2'h0;
  logic [1:0]  ecc_r     = 2'h0;
  logic        we_q      = 1'b1;
  logic        re_q      = 1'b1;
  logic        dev_oe    = 1'b0;
  int          busy_cnt  = 0;
  int          conflicts = 0;
  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
  always @(posedge clk) begin
    we_q <= write_strobe_n;
    re_q <= read_strobe_n;
    // Busy runs on whatever chip select does
    if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
    if (io_oe && dev_oe) conflicts <= conflicts + 1;
    if (!chip_sel_n && write_strobe_n && !we_q) begin
      if (cmd_latch) begin
        log_q.push_back({1'b0, io_out});
        cmd_r  <= io_out;
        acnt_r <= 2'h0;
        ecc_r  <= 2'h0;
        if (io_out == 8'h30 || io_out == 8'h10 || io_out == 8'hFF) busy_cnt <= BUSY_CYC;
      end else if (addr_latch) begin
        log_q.push_back({1'b1, io_out});
        if (acnt_r == 2'h0) col_r[7:0] <= io_out;
        if (acnt_r == 2'h1) col_r[11:8] <= io_out[3:0];
        acnt_r <= acnt_r + 2'h1;
      end else begin
        mem[col_r] <= io_out;
        col_r      <= col_r + 12'h001;
      end
    end
    if (!chip_sel_n && !read_strobe_n && re_q) begin
      dev_oe <= 1'b1;
      if (cmd_r == 8'h7A) begin
        last_r <= 8'hE0 | {6'h00, ecc_r};
        ecc_r  <= ecc_r + 2'h1;
      end else begin
        last_r <= mem[col_r];
        col_r  <= col_r + 12'h001;
      end
    end else if (read_strobe_n && !re_q) begin
      dev_oe <= 1'b0;
    end else if (cmd_latch || addr_latch || chip_sel_n || !write_strobe_n) begin
      // Data also released on latch, select or write, besides the read strobe rise above
      dev_oe <= 1'b0;
    end
  end
  assign ready_busy_n = (busy_cnt == 0) && !stuck;
  assign io_in        = dev_oe ? last_r : ~last_r;
endmodule

// File: verification/tb_nand_flash_bus_interface.sv
// Purpose: Self-checking bench for the flash host sequencer
// Assumes: Short busy watchdog so the timeout path runs quickly
// Notes:   Device side is a behavioural model
`timescale 1ns/10ps
module tb_nand_flash_bus_interface;
  logic        clk = 1'b0, rst_n = 1'b0, start = 1'b0, stuck = 1'b0;
  logic [2:0]  op = 3'h0;
  logic [15:0] column = 16'h0000, row = 16'h0000;
  logic [11:0] length = 12'h000;
  logic [7:0]  wr_byte = 8'h00;
  logic        wr_take_r, rd_valid_r, busy_r, done_r, error_r, chip_sel_n_r;
  logic        cmd_latch, addr_latch, write_strobe_n, read_strobe_n, io_oe, ready_busy_n;
  logic [7:0]  rd_byte_r, io_out, io_in;
  logic [7:0]  rd_q [$];
  logic [7:0]  wq [$];
  int          mismatches = 0, checks = 0, cycles = 0;
  always #4 clk = ~clk;
  nfh_host #(.BUSY_MAX_CYC(200)) uut (
    .clk(clk), .rst_n(rst_n), .start(start), .op(op), .column(column), .row(row),
    .length(length), .wr_byte(wr_byte), .wr_take_r(wr_take_r), .rd_byte_r(rd_byte_r),
    .rd_valid_r(rd_valid_r), .busy_r(busy_r), .done_r(done_r), .error_r(error_r),
    .chip_sel_n_r(chip_sel_n_r), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n));
  nfh_flash_model #(.BUSY_CYC(40)) flash (
    .clk(clk), .chip_sel_n(chip_sel_n_r), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .io_oe(io_oe), .stuck(stuck), .io_in(io_in), .ready_busy_n(ready_busy_n));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      finish_test;
    end
  end
  // Runs one operation; feeds program bytes and gathers read bytes
  task automatic run_op(input logic [2:0] o, input logic [15:0] c, input logic [15:0] r,
                        input logic [11:0] n);
    int k;
    k = 0;
    rd_q.delete();
    flash.log_q.delete();
    @(posedge clk);
    start   <= 1'b1;
    op      <= o;
    column  <= c;
    row     <= r;
    length  <= n;
    wr_byte <= (wq.size() > 0) ? wq[0] : 8'h00;
    @(posedge clk);
    start <= 1'b0;
    while (k < 3000) begin
      @(negedge clk);
      k++;
      if (k == 1) check(16'(busy_r | done_r), 16'h0001);
      if (rd_valid_r === 1'b1) rd_q.push_back(rd_byte_r);
      if (done_r === 1'b1) break;
      if (wr_take_r === 1'b1) begin
        if (wq.size() > 0) void'(wq.pop_front());
        @(posedge clk);
        wr_byte <= (wq.size() > 0) ? wq[0] : 8'h00;
      end
    end
    check(16'(k < 3000), 16'h0001);
    @(negedge clk);
    check(16'(busy_r), 16'h0000);
    check(16'(chip_sel_n_r), 16'h0001);
  endtask
  task automatic check_log(input logic [8:0] e [6]);
    check(16'(flash.log_q.size()), 16'd6);
    foreach (e[i]) check(16'(flash.log_q[i]), 16'(e[i]));
  endtask
  task automatic t_read;
    run_op(3'h0, 16'hF123, 16'hABCD, 12'd3);
    check_log('{9'h000, 9'h123, 9'h101, 9'h1CD, 9'h1AB, 9'h030});
    check(16'(rd_q.size()), 16'd3);
    foreach (rd_q[i]) check(16'(rd_q[i]), 16'((8'h23 + i[7:0]) ^ 8'hA5));
  endtask
  task automatic t_prog;
    wq = '{8'h11, 8'h22};
    run_op(3'h1, 16'h0200, 16'h0040, 12'd2);
    check_log('{9'h080, 9'h100, 9'h102, 9'h140, 9'h100, 9'h010});
    check(16'(flash.mem[12'h200]), 16'h0011);
    check(16'(flash.mem[12'h201]), 16'h0022);
    check(16'(error_r), 16'h0000);
    run_op(3'h0, 16'h0200, 16'h0040, 12'd2);
    check(16'(rd_q[0]), 16'h0011);
    check(16'(rd_q[1]), 16'h0022);
  endtask
  // Status command must follow a read's busy with no data out between
  task automatic t_ecc;
    run_op(3'h0, 16'h0000, 16'h0000, 12'd0);
    run_op(3'h2, 16'h0000, 16'h0000, 12'd0);
    check(16'(flash.log_q[0]), 16'h007A);
    check(16'(rd_q.size()), 16'd4);
    foreach (rd_q[i]) check(16'(rd_q[i]), 16'(8'hE0 + i[7:0]));
  endtask
  task automatic t_reset;
    run_op(3'h3, 16'h0000, 16'h0000, 12'd0);
    check(16'(flash.log_q[0]), 16'h00FF);
    check(16'(error_r), 16'h0000);
  endtask
  // Fifth program to one page must be refused without bus traffic
  task automatic t_partial;
    for (int i = 0; i < 5; i++) begin
      wq = '{8'h30 + 8'(i)};
      run_op(3'h1, 16'(i * 16), 16'h0080, 12'd1);
      check(16'(error_r), 16'(i == 4));
      check(16'(flash.log_q.size()), (i == 4) ? 16'd0 : 16'd6);
    end
    run_op(3'h4, 16'h0000, 16'h0080, 12'd0);
    wq = '{8'h55};
    run_op(3'h1, 16'h0300, 16'h0080, 12'd1);
    check(16'(error_r), 16'h0000);
    check(16'(flash.mem[12'h300]), 16'h0055);
  endtask
  // Device never returns ready: watchdog must flag it
  task automatic t_timeout;
    @(posedge clk);
    stuck <= 1'b1;
    run_op(3'h0, 16'h0000, 16'h0001, 12'd1);
    check(16'(error_r), 16'h0001);
    check(16'(rd_q.size()), 16'd0);
    @(posedge clk);
    stuck <= 1'b0;
    t_reset;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_read;
    t_ecc;
    t_prog;
    t_reset;
    t_partial;
    t_timeout;
    check(16'(flash.conflicts), 16'h0000);
    finish_test;
  end
endmodule
